// >>> rtl/sfos_core.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Enter command switches to separate 512-bit one-time-programmable region.
// - In that mode ordinary read and program go to the region.
// - In that mode status and lock register writes are refused.
// - After lockdown only reads act on the region; content never changes.
// - Exit command returns read and program to the main array.
// - Lock register read works any time and repeats while clocked.
// - Bit0 reports factory lock; nonvolatile.
// - Bit1 customer lock; once 1 neither it nor the region changes.
// - In that mode no main array access is passed on.
// - Lock register write needs no write-enable latch.
// - Lock register write must be exactly its one opcode byte, else ignored.
// - Chip select high ends table read and stops output at once.
// - Table bytes 0 to 3 return the fixed signature.
// - Bytes 4 to 7 return revisions, header count and unused byte.
// - First header: id, minor, major revision, table length.
module sfos_core #(
   parameter logic [7:0] OP_ENTER_OTP = 8'hb1,
   parameter logic [7:0] OP_EXIT_OTP  = 8'hc1,
   parameter logic [7:0] OP_WR_LATCH  = 8'h06,
   parameter logic [7:0] OP_WR_STAT   = 8'h01,
   parameter logic [7:0] OP_READ      = 8'h03,
   parameter logic [7:0] OP_PROG      = 8'h02,
   parameter logic       CUST_LOCK_INIT = 1'b0
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        SCLK,
   input  wire logic        CS_N,
   input  wire logic        SI,
   input  wire logic        FACTORY_LOCK,
   output logic             SO,
   output logic             SO_OE,
   output logic             OTP_MODE,
   output logic [7:0]       LOCK_REG,
   output logic             WRITE_LATCH,
   output logic             STAT_WR_REQ,
   output logic [7:0]       STAT_WR_DATA,
   output logic             ARRAY_REQ,
   output logic [7:0]       ARRAY_OP,
   output logic [23:0]      ARRAY_ADDR
);

   // ****************************************************************
   // Link side: shift in, decode, shift out (SCLK domain)
   // ****************************************************************
   logic                       rst_frame;
   logic [2:0]                 bit_cnt_r;
   logic [2:0]                 byte_cnt_r;
   logic [2:0]                 byte_cnt_nxt;
   logic [6:0]                 shift_r;
   logic [7:0]                 opcode_r;
   logic [7:0]                 opcode_nxt;
   logic [23:0]                addr_r;
   logic [23:0]                addr_nxt;
   logic [23:0]                cur_addr_r;
   logic [23:0]                cur_addr_nxt;
   logic                       byte_done;
   logic [7:0]                 byte_in;
   logic [2:0]                 data_start;
   logic                       has_data;
   logic                       in_data;
   logic [7:0]                 tx_byte;
   logic [7:0]                 lock_byte_l;
   logic [7:0]                 otp_rdata;
   logic                       otp_we;
   logic                       so_r;
   logic                       so_oe_r;
   logic [3:0]                 st_q1_r;
   logic [3:0]                 st_q2_r;
   logic                       otp_s;
   logic                       cust_s;
   logic                       fact_s;
   logic                       wel_s;
   logic                       otp_mode_r;
   logic                       cust_lock_r;
   logic                       factory_r;
   logic                       wel_r;
   sfos_pkg::sfos_rec_t        rec_r;

   // Frame logic restarts whenever chip select is high
   assign rst_frame = RST | CS_N;
   assign byte_done = (bit_cnt_r == 3'h7);
   assign byte_in   = {shift_r, SI};
   assign otp_s     = st_q2_r[0];
   assign cust_s    = st_q2_r[1];
   assign fact_s    = st_q2_r[2];
   assign wel_s     = st_q2_r[3];

   // Core state only changes between frames, so the copies are settled by then
   always_ff @(posedge SCLK or posedge RST) begin
      if (RST) begin
         st_q1_r <= 4'h0;
         st_q2_r <= 4'h0;
      end else begin
         st_q1_r <= {wel_r, factory_r, cust_lock_r, otp_mode_r};
         st_q2_r <= st_q1_r;
      end
   end

   always_comb begin
      byte_cnt_nxt = byte_cnt_r;
      opcode_nxt   = opcode_r;
      addr_nxt     = addr_r;
      if (byte_done) begin
         if (byte_cnt_r != sfos_pkg::CNT_MAX) begin
            byte_cnt_nxt = byte_cnt_r + 3'h1;
         end
         if (byte_cnt_r == 3'h0) begin
            opcode_nxt = byte_in;
         end else if (byte_cnt_r <= sfos_pkg::ADDR_LAST) begin
            addr_nxt = {addr_r[15:0], byte_in};
         end
      end
   end

   // Where each command's outgoing data begins
   always_comb begin
      data_start = sfos_pkg::NO_START;
      has_data   = 1'b0;
      case (opcode_r)
         sfos_pkg::OP_RD_LOCK: begin
            data_start = sfos_pkg::LOCK_START;
            has_data   = 1'b1;
         end
         sfos_pkg::OP_RD_PARAM: begin
            data_start = sfos_pkg::PARAM_START;
            has_data   = 1'b1;
         end
         OP_READ: begin
            data_start = sfos_pkg::MEM_START;
            has_data   = otp_s;
         end
         default: begin
            data_start = sfos_pkg::NO_START;
            has_data   = 1'b0;
         end
      endcase
   end

   assign in_data = has_data && (byte_cnt_r >= data_start) && (byte_cnt_r != 3'h0);

   always_comb begin
      cur_addr_nxt = cur_addr_r;
      if (byte_done && byte_cnt_r == sfos_pkg::ADDR_LAST) begin
         cur_addr_nxt = addr_nxt;
      end else if (byte_done && byte_cnt_r >= sfos_pkg::MEM_START &&
                   (opcode_r != sfos_pkg::OP_RD_PARAM || byte_cnt_r != sfos_pkg::MEM_START)) begin
         cur_addr_nxt = cur_addr_r + 24'h000001;
      end
   end

   always_ff @(posedge SCLK or posedge rst_frame) begin
      if (rst_frame) begin
         bit_cnt_r  <= 3'h0;
         byte_cnt_r <= 3'h0;
         shift_r    <= 7'h00;
         opcode_r   <= 8'h00;
         addr_r     <= 24'h000000;
         cur_addr_r <= 24'h000000;
      end else begin
         bit_cnt_r  <= bit_cnt_r + 3'h1;
         byte_cnt_r <= byte_cnt_nxt;
         shift_r    <= byte_in[6:0];
         opcode_r   <= opcode_nxt;
         addr_r     <= addr_nxt;
         cur_addr_r <= cur_addr_nxt;
      end
   end

   // Snapshot survives chip select so the core can read it afterwards
   always_ff @(posedge SCLK or posedge RST) begin
      if (RST) begin
         rec_r <= '0;
      end else begin
         rec_r.op      <= opcode_nxt;
         rec_r.cnt     <= byte_cnt_nxt;
         rec_r.aligned <= (bit_cnt_r == 3'h7);
         rec_r.addr    <= addr_nxt;
         if (byte_done && byte_cnt_r == sfos_pkg::OPC_BYTES) begin
            rec_r.data <= byte_in;
         end
         if (bit_cnt_r == 3'h0 && byte_cnt_r == 3'h0) begin
            rec_r.seq <= ~rec_r.seq;
         end
      end
   end

   // Program goes straight into the region, byte by byte
   assign otp_we = byte_done && in_data_prog() && otp_s && wel_s && !cust_s;

   function automatic logic in_data_prog();
      return (opcode_r == OP_PROG) && (byte_cnt_r >= sfos_pkg::MEM_START);
   endfunction

   sfos_mem #(
      .DW    (8),
      .DEPTH (sfos_pkg::OTP_BYTES),
      .AW    (sfos_pkg::OTP_AW)
   ) u_otp (
      .clk   (SCLK),
      .we    (otp_we),
      .waddr (cur_addr_r[sfos_pkg::OTP_AW-1:0]),
      .wdata (byte_in),
      .raddr (cur_addr_nxt[sfos_pkg::OTP_AW-1:0]),
      .rdata (otp_rdata)
   );

   assign lock_byte_l = {sfos_pkg::LOCK_RSVD, cust_s, fact_s};

   always_comb begin
      case (opcode_r)
         sfos_pkg::OP_RD_LOCK:  tx_byte = lock_byte_l;
         sfos_pkg::OP_RD_PARAM: tx_byte = sfos_pkg::param_byte(cur_addr_r);
         OP_READ:               tx_byte = otp_rdata;
         default:               tx_byte = sfos_pkg::READ_FILL;
      endcase
   end

   // Launch on the falling edge; chip select high drops the drive at once
   always_ff @(negedge SCLK or posedge rst_frame) begin
      if (rst_frame) begin
         so_r    <= 1'b0;
         so_oe_r <= 1'b0;
      end else begin
         so_r    <= tx_byte[~bit_cnt_r];
         so_oe_r <= in_data;
      end
   end

   assign SO    = so_r;
   assign SO_OE = so_oe_r;

   // ****************************************************************
   // Core side: persistent state and frame-end commands (CLK domain)
   // ****************************************************************
   logic       cs_q1_r;
   logic       cs_q2_r;
   logic       cs_q3_r;
   logic       seq_q1_r;
   logic       seq_q2_r;
   logic       seen_r;
   logic       frame_end;
   logic       fl_q1_r;
   logic       fl_q2_r;
   logic [1:0] strap_cnt_r;
   logic       stat_req_r;
   logic [7:0] stat_data_r;
   logic       arr_req_r;
   logic [7:0] arr_op_r;
   logic [23:0] arr_addr_r;
   logic       whole_op;
   logic       wr_lock_ok;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cs_q1_r  <= 1'b1;
         cs_q2_r  <= 1'b1;
         cs_q3_r  <= 1'b1;
         seq_q1_r <= 1'b0;
         seq_q2_r <= 1'b0;
         fl_q1_r  <= 1'b0;
         fl_q2_r  <= 1'b0;
      end else begin
         cs_q1_r  <= CS_N;
         cs_q2_r  <= cs_q1_r;
         cs_q3_r  <= cs_q2_r;
         seq_q1_r <= rec_r.seq;
         seq_q2_r <= seq_q1_r;
         fl_q1_r  <= FACTORY_LOCK;
         fl_q2_r  <= fl_q1_r;
      end
   end

   // A frame with no clock edges leaves the sequence bit alone and is skipped
   assign frame_end  = cs_q2_r && !cs_q3_r && (seq_q2_r != seen_r);
   assign whole_op   = rec_r.aligned && (rec_r.cnt == sfos_pkg::OPC_BYTES);
   assign wr_lock_ok = (rec_r.op == sfos_pkg::OP_WR_LOCK) && whole_op && !otp_mode_r;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         seen_r <= 1'b0;
      end else if (frame_end) begin
         seen_r <= seq_q2_r;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         otp_mode_r <= sfos_pkg::OTP_MODE_RST;
      end else if (frame_end && whole_op && rec_r.op == OP_ENTER_OTP) begin
         otp_mode_r <= 1'b1;
      end else if (frame_end && whole_op && rec_r.op == OP_EXIT_OTP) begin
         otp_mode_r <= 1'b0;
      end
   end

   // Customer lock only ever sets
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cust_lock_r <= CUST_LOCK_INIT;
      end else if (frame_end && wr_lock_ok) begin
         cust_lock_r <= 1'b1;
      end
   end

   // Factory strap caught once after reset release, then held
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         strap_cnt_r <= 2'h0;
         factory_r   <= 1'b0;
      end else if (strap_cnt_r != sfos_pkg::STRAP_CYC) begin
         strap_cnt_r <= strap_cnt_r + 2'h1;
         factory_r   <= fl_q2_r;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wel_r <= sfos_pkg::WEL_RST;
      end else if (frame_end && whole_op && rec_r.op == OP_WR_LATCH) begin
         wel_r <= 1'b1;
      end else if (frame_end && (rec_r.op == OP_PROG || rec_r.op == OP_WR_STAT)) begin
         wel_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         stat_req_r  <= 1'b0;
         stat_data_r <= 8'h00;
      end else begin
         stat_req_r <= frame_end && rec_r.op == OP_WR_STAT && rec_r.aligned &&
                       rec_r.cnt == sfos_pkg::STAT_LEN && wel_r && !otp_mode_r;
         if (frame_end) begin
            stat_data_r <= rec_r.data;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         arr_req_r  <= 1'b0;
         arr_op_r   <= 8'h00;
         arr_addr_r <= 24'h000000;
      end else begin
         arr_req_r <= frame_end && !otp_mode_r &&
                      (rec_r.op == OP_READ || rec_r.op == OP_PROG) &&
                      rec_r.cnt >= sfos_pkg::MEM_START;
         if (frame_end) begin
            arr_op_r   <= rec_r.op;
            arr_addr_r <= rec_r.addr;
         end
      end
   end

   assign OTP_MODE     = otp_mode_r;
   assign LOCK_REG     = {sfos_pkg::LOCK_RSVD, cust_lock_r, factory_r};
   assign WRITE_LATCH  = wel_r;
   assign STAT_WR_REQ  = stat_req_r;
   assign STAT_WR_DATA = stat_data_r;
   assign ARRAY_REQ    = arr_req_r;
   assign ARRAY_OP     = arr_op_r;
   assign ARRAY_ADDR   = arr_addr_r;

endmodule

// >>> rtl/sfos_pkg.sv
package sfos_pkg;

   // ****************************************************************
   // Opcodes and frame layout
   // ****************************************************************
   localparam logic [7:0] OP_RD_LOCK  = 8'h2b;
   localparam logic [7:0] OP_WR_LOCK  = 8'h2f;
   localparam logic [7:0] OP_RD_PARAM = 8'h5a;

   localparam logic [2:0] OPC_BYTES   = 3'h1;
   localparam logic [2:0] ADDR_BYTES  = 3'h3;
   localparam logic [2:0] DUMMY_BYTES = 3'h1;
   localparam logic [2:0] ADDR_LAST   = OPC_BYTES + ADDR_BYTES - 3'h1;
   localparam logic [2:0] MEM_START   = OPC_BYTES + ADDR_BYTES;
   localparam logic [2:0] PARAM_START = OPC_BYTES + ADDR_BYTES + DUMMY_BYTES;
   localparam logic [2:0] LOCK_START  = OPC_BYTES;
   localparam logic [2:0] NO_START    = 3'h7;
   localparam logic [2:0] WR_LOCK_LEN = OPC_BYTES;
   localparam logic [2:0] STAT_LEN    = OPC_BYTES + 3'h1;
   localparam logic [2:0] CNT_MAX     = 3'h7;

   // ****************************************************************
   // One-time-programmable region and lock register
   // ****************************************************************
   localparam int         OTP_BITS     = 512;
   localparam int         OTP_BYTES    = OTP_BITS / 8;
   localparam int         OTP_AW       = $clog2(OTP_BYTES);
   localparam int         LOCK_FACT    = 0;
   localparam int         LOCK_CUST    = 1;
   localparam logic [5:0] LOCK_RSVD    = 6'h00;
   localparam logic       OTP_MODE_RST = 1'b0;
   localparam logic       WEL_RST      = 1'b0;
   localparam logic [1:0] STRAP_CYC    = 2'h3;
   localparam logic [7:0] READ_FILL    = 8'hff;

   // ****************************************************************
   // Parameter table header
   // ****************************************************************
   localparam logic [7:0] PT_SIG0      = 8'h53;
   localparam logic [7:0] PT_SIG1      = 8'h46;
   localparam logic [7:0] PT_SIG2      = 8'h44;
   localparam logic [7:0] PT_SIG3      = 8'h50;
   localparam logic [7:0] PT_MINOR     = 8'h00;
   localparam logic [7:0] PT_MAJOR     = 8'h01;
   localparam logic [7:0] PT_NHDR      = 8'h01;
   localparam logic [7:0] PT_UNUSED    = 8'hff;
   localparam logic [7:0] PH_ID        = 8'h00;
   localparam logic [7:0] PH_MINOR     = 8'h00;
   localparam logic [7:0] PH_MAJOR     = 8'h01;
   localparam logic [7:0] PH_LEN       = 8'h09;
   localparam logic [7:0] PT_FILL      = 8'hff;

   function automatic logic [7:0] param_byte(input logic [23:0] addr);
      logic [7:0] b;
      b = PT_FILL;
      if (addr[23:4] == 20'h00000) begin
         case (addr[3:0])
            4'h0:    b = PT_SIG0;
            4'h1:    b = PT_SIG1;
            4'h2:    b = PT_SIG2;
            4'h3:    b = PT_SIG3;
            4'h4:    b = PT_MINOR;
            4'h5:    b = PT_MAJOR;
            4'h6:    b = PT_NHDR;
            4'h7:    b = PT_UNUSED;
            4'h8:    b = PH_ID;
            4'h9:    b = PH_MINOR;
            4'ha:    b = PH_MAJOR;
            4'hb:    b = PH_LEN;
            default: b = PT_FILL;
         endcase
      end
      return b;
   endfunction

   // Snapshot of a frame, left standing by the link side for the core
   typedef struct packed {
      logic [7:0]  op;
      logic [2:0]  cnt;
      logic        aligned;
      logic [23:0] addr;
      logic [7:0]  data;
      logic        seq;
   } sfos_rec_t;

endpackage

// >>> rtl/sfos_mem.sv
`timescale 1ns/100ps
module sfos_mem #(
   parameter int DW    = 8,
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   input  wire logic          clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);

   logic [DW-1:0] mem_r [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem_r[waddr] <= wdata;
      end
   end

   // Registered read; write-first is not needed, reads lead writes
   always_ff @(posedge clk) begin
      rdata <= mem_r[raddr];
   end

endmodule

// >>> test/sfos_core_sva.sv
`timescale 1ns/100ps
// ********
// Mode, lock and link-enable checks
// ********
module sfos_core_sva (
   input wire logic       CLK,
   input wire logic       RST,
   input wire logic       CS_N,
   input wire logic       FACTORY_LOCK,
   input wire logic       SO_OE,
   input wire logic       OTP_MODE,
   input wire logic [7:0] LOCK_REG,
   input wire logic       STAT_WR_REQ,
   input wire logic       ARRAY_REQ
);
   logic [2:0] rel_cnt_r;

   // Saturates so the strap check fires once the sample has settled
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rel_cnt_r <= 3'h0;
      end else if (rel_cnt_r != 3'h4) begin
         rel_cnt_r <= rel_cnt_r + 3'h1;
      end
   end

   default clocking dc @(posedge CLK); endclocking
   default disable iff (RST);

   a_mode_at_end: assert property (
      $changed(OTP_MODE) |-> $past(CS_N) && $past(CS_N, 2)) else $error("Mode changed inside a frame");
   a_stat_not_otp: assert property (
      STAT_WR_REQ |-> !$past(OTP_MODE) ##1 !STAT_WR_REQ) else $error("Status write passed in region mode");
   a_lock_not_otp: assert property (
      $rose(LOCK_REG[1]) |-> !$past(OTP_MODE) && $past(CS_N)) else $error("Lock set in region mode");
   a_array_blocked: assert property (
      ARRAY_REQ |-> !$past(OTP_MODE) ##1 !ARRAY_REQ) else $error("Array access in region mode");
   a_cust_sticky: assert property (
      $past(LOCK_REG[1]) |-> LOCK_REG[1]) else $error("Customer lock cleared");
   a_rsvd_zero: assert property (
      LOCK_REG[7:2] == 6'h00) else $error("Reserved lock bits set");
   a_fact_strap: assert property (
      rel_cnt_r == 3'h4 |-> LOCK_REG[0] == FACTORY_LOCK && $stable(LOCK_REG[0])) else $error("Factory bit wrong");
   a_oe_off_cs: assert property (
      CS_N |-> !SO_OE) else $error("Output driven while deselected");
endmodule

bind sfos_core sfos_core_sva chk_u (
   .CLK          (CLK),
   .RST          (RST),
   .CS_N         (CS_N),
   .FACTORY_LOCK (FACTORY_LOCK),
   .SO_OE        (SO_OE),
   .OTP_MODE     (OTP_MODE),
   .LOCK_REG     (LOCK_REG),
   .STAT_WR_REQ  (STAT_WR_REQ),
   .ARRAY_REQ    (ARRAY_REQ)
);

// >>> test/sfos_host.sv
`timescale 1ns/100ps
// ********
// Host controller: mode 0, clock still between frames
// ********
module sfos_host (
   output logic           sclk,
   output logic           cs_n,
   output logic           si,
   input  wire logic      so,
   input  wire logic      so_oe
);
   logic [7:0] rx_q[$];
   logic       oe_bad;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      oe_bad = 1'b0;
   end

   // Sends nb bits of tx from the top, then clocks in nrx bits
   task automatic xfer(input logic [39:0] tx, input int nb, input int nrx);
      logic [7:0] b;
      rx_q = {};
      oe_bad = 1'b0;
      b = 8'h00;
      cs_n = 1'b0;
      #16.3;
      for (int i = 0; i < nb + nrx; i++) begin
         // Command bits MSB first; after them SI toggles as a don't-care
         si = (i < nb) ? tx[39 - i] : i[0];
         #16;
         sclk = 1'b1;
         if (i >= nb) begin
            b = {b[6:0], so};
            oe_bad = oe_bad | (so_oe !== 1'b1);
            if ((i - nb) % 8 == 7) begin
               rx_q.push_back(b);
            end
         end
         #16;
         sclk = 1'b0;
      end
      #16;
      // May end mid-byte or off the boundary when a test asks for it
      cs_n = 1'b1;
      si = ~si;
      #80;
   endtask
endmodule

// >>> test/serial_flash_otp_security_sfdp_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module serial_flash_otp_security_sfdp_tb_top;
   logic        clk, rst, sclk, cs_n, si, fact, so, so_oe, otp_mode, wr_latch, stat_req, arr_req;
   logic [7:0]  lock_reg, stat_data, arr_op;
   logic [23:0] arr_addr;
   int          fails, checks_done, arr_n, stat_n;
   localparam logic [95:0] PT_EXP = 96'h53464450_000101ff_00000109;

   initial clk = 1'b0;
   always #5 clk = ~clk;

   sfos_core dut_u (
      .CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SI(si), .FACTORY_LOCK(fact), .SO(so),
      .SO_OE(so_oe), .OTP_MODE(otp_mode), .LOCK_REG(lock_reg), .WRITE_LATCH(wr_latch),
      .STAT_WR_REQ(stat_req), .STAT_WR_DATA(stat_data), .ARRAY_REQ(arr_req), .ARRAY_OP(arr_op),
      .ARRAY_ADDR(arr_addr)
   );

   sfos_host host_u (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));

   always @(posedge clk) begin
      if (arr_req === 1'b1) arr_n++;
      if (stat_req === 1'b1) stat_n++;
   end

   task automatic do_reset(input logic strap);
      @(negedge clk);
      rst = 1'b1;
      fact = strap;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (5) @(negedge clk);
   endtask

   task automatic frm(input logic [39:0] tx, input int nb, input int nrx);
      @(negedge clk);
      host_u.xfer(tx, nb, nrx);
      @(negedge clk);
   endtask

   task automatic t_reset;
      do_reset(1'b0);
      `CHK("otp_mode", 1'b0, otp_mode)
      `CHK("lock_reg", 8'h00, lock_reg)
      do_reset(1'b1);
      `CHK("lock_reg", 8'h01, lock_reg)
      frm({sfos_pkg::OP_RD_LOCK, 32'h0}, 8, 24);
      for (int i = 0; i < 3; i++) `CHK("lock_rd", 8'h01, host_u.rx_q[i])
      $display("test reset done");
   endtask

   task automatic t_table;
      frm({sfos_pkg::OP_RD_PARAM, 32'h0}, 40, 96);
      for (int i = 0; i < 4; i++) `CHK("sig", PT_EXP[95-8*i -: 8], host_u.rx_q[i])
      for (int i = 4; i < 8; i++) `CHK("hdr", PT_EXP[95-8*i -: 8], host_u.rx_q[i])
      for (int i = 8; i < 12; i++) `CHK("phdr", PT_EXP[95-8*i -: 8], host_u.rx_q[i])
      `CHK("drive", 1'b0, host_u.oe_bad)
      `CHK("oe_end", 1'b0, so_oe)
      // Stop five bits into the second byte
      frm({sfos_pkg::OP_RD_PARAM, 24'h00000a, 8'hff}, 40, 13);
      `CHK("mid", 8'h01, host_u.rx_q[0])
      `CHK("oe_abort", 1'b0, so_oe)
      $display("test table done");
   endtask

   task automatic t_otp;
      int a0, s0;
      a0 = arr_n;
      s0 = stat_n;
      frm({8'hb1, 32'h0}, 8, 0);
      `CHK("enter", 1'b1, otp_mode)
      frm({8'h06, 32'h0}, 8, 0);
      `CHK("latch_on", 1'b1, wr_latch)
      frm({8'h02, 24'h000010, 8'ha5}, 40, 0);
      frm({8'h03, 24'h000010, 8'h00}, 32, 8);
      `CHK("otp_rd", 8'ha5, host_u.rx_q[0])
      frm({8'h06, 32'h0}, 8, 0);
      frm({8'h01, 8'h00, 24'h0}, 16, 0);
      `CHK("stat_otp", s0, stat_n)
      frm({sfos_pkg::OP_WR_LOCK, 32'h0}, 8, 0);
      `CHK("lock_otp", 8'h01, lock_reg)
      `CHK("no_array", a0, arr_n)
      frm({8'hc1, 32'h0}, 8, 0);
      `CHK("exit", 1'b0, otp_mode)
      frm({8'h03, 24'h123456, 8'h00}, 32, 0);
      `CHK("array", a0 + 1, arr_n)
      `CHK("arr_addr", 24'h123456, arr_addr)
      `CHK("arr_op", 8'h03, arr_op)
      frm({8'h06, 32'h0}, 8, 0);
      frm({8'h01, 8'h3c, 24'h0}, 16, 0);
      `CHK("stat_main", s0 + 1, stat_n)
      `CHK("stat_data", 8'h3c, stat_data)
      $display("test otp done");
   endtask

   task automatic t_lockdown;
      frm({sfos_pkg::OP_WR_LOCK, 32'h0}, 9, 0);
      `CHK("lock_9bit", 8'h01, lock_reg)
      `CHK("no_latch", 1'b0, wr_latch)
      frm({sfos_pkg::OP_WR_LOCK, 32'h0}, 8, 0);
      `CHK("lock_set", 8'h03, lock_reg)
      frm({sfos_pkg::OP_RD_LOCK, 32'h0}, 8, 8);
      `CHK("lock_rd", 8'h03, host_u.rx_q[0])
      frm({8'hb1, 32'h0}, 8, 0);
      frm({8'h06, 32'h0}, 8, 0);
      frm({8'h02, 24'h000010, 8'h5a}, 40, 0);
      frm({8'h03, 24'h000010, 8'h00}, 32, 8);
      `CHK("frozen", 8'ha5, host_u.rx_q[0])
      frm({8'hc1, 32'h0}, 8, 0);
      $display("test lockdown done");
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      fact = 1'b0;
      fails = 0;
      checks_done = 0;
      arr_n = 0;
      stat_n = 0;
      t_reset;
      t_table;
      t_otp;
      t_lockdown;
      end_sim;
   end

   // About twenty times the expected run length
   initial begin
      #400000;
      fails++;
      $display("watchdog expired");
      end_sim;
   end
endmodule
